// >>> design/dbghc_top.sv
// Debug controller halt entry, clock select and command gating logic
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Halt only while enable bit set
// - Halt on request, instruction or breakpoint
// - Special single chip reset starts halted
// - Ready for commands ten cycles after reset
// - Always-available run during init; others wait
// - Finish instruction; only debug touches registers
// - Breakpoint type picks halt before/after
// - Disabled: ignore halt request, no delay
// - Select bit picks constant or fast clock
// - Internal accesses run on core clock
// - Always-available commands accepted in any state
// - Non-intrusive need enabled and unsecure
// - Active commands need unsecure and halted
// - Active set: registers, step, resume
// - Non-intrusive also run while halted
// - No handshake: cycle_take_bit next bus cycles
// - Illegal command sets flag, reads 0xEE
// - Handshake wait 512 cycles, then abort
module dbghc_top (
    // Core clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    // Device state
    input  wire logic                     ssc_mode,
    input  wire logic                     secure,
    input  wire logic                     nvm_init_busy,
    // Serial side command and answer
    input  wire dbghc_pkg::dbghc_cmd_req_t cmd_req,
    input  wire logic                     cmd_tgl,
    input  wire logic                     flag_clr_illegal,
    input  wire logic                     flag_clr_no_response_flag,
    output logic                          cmd_ready,
    output dbghc_pkg::dbghc_cmd_rsp_t     cmd_rsp,
    // CPU interface
    input  wire logic                     cpu_halt_instruction,
    input  wire logic                     bp_hit,
    input  wire logic                     bp_after_next,
    input  wire logic                     instr_done,
    output logic                          cpu_halt,
    output logic                          cpu_regs_lock,
    // System bus
    input  wire logic                     bus_free,
    input  wire logic                     bus_ack,
    input  wire logic [7:0]               bus_rdata,
    output logic                          bus_req,
    output logic                          bus_cycle_take_bit,
    // Status and clock select
    output logic                          debug_enable_bit,
    output logic                          clock_select_bit,
    output logic                          halted_debug_mode,
    output logic                          illegal_command_flag,
    output logic                          no_response_flag
);

    dbghc_pkg::dbghc_state_t s_q;
    dbghc_pkg::dbghc_state_t s_d;

    // Always-available classes; the gate and the init hold both use it
    function automatic logic cmd_always(input dbghc_pkg::dbghc_cmd_t c);
        cmd_always = (c == dbghc_pkg::DBGHC_CMD_ALWAYS) ||
                     (c == dbghc_pkg::DBGHC_CMD_CSR_WR);
    endfunction

    // Class check shared by new and held commands
    // Security outranks enable, so a secure part only takes control words
    function automatic logic cmd_legal(input dbghc_pkg::dbghc_cmd_t c,
                                       input logic en, input logic sec,
                                       input logic halted);
        if (cmd_always(c)) begin
            cmd_legal = 1'b1;
        end else begin
            case (c)
                dbghc_pkg::DBGHC_CMD_NONINTR,
                dbghc_pkg::DBGHC_CMD_HALT_REQ: begin
                    cmd_legal = en && !sec;
                end
                dbghc_pkg::DBGHC_CMD_ACTIVE,
                dbghc_pkg::DBGHC_CMD_RESUME,
                dbghc_pkg::DBGHC_CMD_STEP: begin
                    cmd_legal = halted && !sec;
                end
                default: begin
                    cmd_legal = 1'b0;
                end
            endcase
        end
    endfunction

    logic                     new_cmd;
    logic                     halted;
    dbghc_pkg::dbghc_cmd_req_t cur;
    logic                     cur_go;
    // Same-cycle set events, so a clear pulse cannot swallow a new error
    logic                     ill_set;
    logic                     nr_set;

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        halted = (s_q.cpu_st == dbghc_pkg::DBGHC_HALTED);
        s_d.rsp.done = 1'b0;
        s_d.rsp.long_ack = 1'b0;
        ill_set = 1'b0;
        nr_set = 1'b0;
        // Toggle handshake from the serial clock domain
        // Only the toggle is synced; the sender holds cmd_req still meanwhile
        s_d.s1_req = cmd_tgl;
        s_d.s2_req = s_q.s1_req;
        s_d.s2_req_d = s_q.s2_req;
        new_cmd = s_q.ready && (s_q.s2_req != s_q.s2_req_d);

        // Reset-release delay before the first command
        if (!s_q.ready) begin
            if (s_q.rdy_cnt == dbghc_pkg::READY_CNT - dbghc_pkg::CNT4_ONE) begin
                s_d.ready = 1'b1;
            end
            s_d.rdy_cnt = s_q.rdy_cnt + dbghc_pkg::CNT4_ONE;
        end

        // Capture a command; non always-available ones wait out NVM init
        if (new_cmd) begin
            s_d.held = cmd_req;
            s_d.held_pend = 1'b1;
        end
        cur = new_cmd ? cmd_req : s_q.held;
        cur_go = (new_cmd || s_q.held_pend) && s_q.bus_st ==
                 dbghc_pkg::DBGHC_BUS_IDLE &&
                 (!nvm_init_busy || cmd_always(cur.cls));

        if (cur_go) begin
            s_d.held_pend = 1'b0;
            if (!cmd_legal(cur.cls, s_q.enable, secure, halted)) begin
                // Halt request while disabled is dropped, CPU untouched
                s_d.illegal_flag = 1'b1;
                ill_set = 1'b1;
                s_d.rsp.done = 1'b1;
                s_d.rsp.rd_byte = dbghc_pkg::ERR_DATA_BYTE;
            end else begin
                case (cur.cls)
                    dbghc_pkg::DBGHC_CMD_CSR_WR: begin
                        s_d.enable = cur.csr_enable;
                        s_d.clk_sel = cur.csr_clk_sel;
                        s_d.rsp.done = 1'b1;
                    end
                    dbghc_pkg::DBGHC_CMD_HALT_REQ: begin
                        if (s_q.cpu_st == dbghc_pkg::DBGHC_RUN) begin
                            s_d.cpu_st = dbghc_pkg::DBGHC_FINISH;
                        end
                        s_d.rsp.done = 1'b1;
                    end
                    dbghc_pkg::DBGHC_CMD_RESUME: begin
                        s_d.cpu_st = dbghc_pkg::DBGHC_RUN;
                        s_d.rsp.done = 1'b1;
                    end
                    dbghc_pkg::DBGHC_CMD_STEP: begin
                        s_d.cpu_st = dbghc_pkg::DBGHC_STEPPING;
                        s_d.rsp.done = 1'b1;
                    end
                    dbghc_pkg::DBGHC_CMD_NONINTR,
                    dbghc_pkg::DBGHC_CMD_ACTIVE: begin
                        // Memory or register access on the core clock
                        s_d.bus_st = (s_q.ack_en && !s_q.cycle_take) ?
                                     dbghc_pkg::DBGHC_BUS_WAIT :
                                     dbghc_pkg::DBGHC_BUS_BUSY;
                        s_d.bus_req = 1'b1;
                        s_d.wait_cnt = '0;
                    end
                    default: begin
                        s_d.rsp.done = 1'b1;
                    end
                endcase
            end
        end

        // Bus engine: cycle_take_bit at once, or wait for a free cycle with timeout
        case (s_q.bus_st)
            dbghc_pkg::DBGHC_BUS_WAIT: begin
                if (bus_free) begin
                    s_d.bus_st = dbghc_pkg::DBGHC_BUS_BUSY;
                end else if (s_q.wait_cnt == dbghc_pkg::CYCLE_TAKE_BIT_WAIT_CNT -
                             dbghc_pkg::CNT10_ONE) begin
                    s_d.bus_st = dbghc_pkg::DBGHC_BUS_IDLE;
                    s_d.bus_req = 1'b0;
                    s_d.no_resp_flag = 1'b1;
                    nr_set = 1'b1;
                    s_d.rsp.long_ack = 1'b1;
                    s_d.rsp.done = 1'b1;
                    s_d.rsp.rd_byte = dbghc_pkg::ERR_DATA_BYTE;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt + dbghc_pkg::CNT10_ONE;
                end
            end
            dbghc_pkg::DBGHC_BUS_BUSY: begin
                // Multi-cycle accesses keep the request up until ack
                if (bus_ack) begin
                    s_d.bus_st = dbghc_pkg::DBGHC_BUS_IDLE;
                    s_d.bus_req = 1'b0;
                    s_d.rsp.done = 1'b1;
                    s_d.rsp.rd_byte = bus_rdata;
                end
            end
            dbghc_pkg::DBGHC_BUS_IDLE: begin
                // Keep whatever the command decode above started
            end
            default: begin
                // Stray code: drop the access rather than hang the host
                s_d.bus_st = dbghc_pkg::DBGHC_BUS_IDLE;
                s_d.bus_req = 1'b0;
            end
        endcase

        // Halt sources from the CPU and breakpoint unit, gated by enable
        // Disabled: the halt instruction just runs and never stalls the CPU
        if (s_q.enable && s_q.cpu_st == dbghc_pkg::DBGHC_RUN) begin
            if (cpu_halt_instruction) begin
                s_d.cpu_st = dbghc_pkg::DBGHC_FINISH;
            end else if (bp_hit) begin
                s_d.cpu_st = dbghc_pkg::DBGHC_FINISH;
                s_d.bp_after = bp_after_next;
            end
        end

        // CPU sequencing: finish current (and maybe next) instruction
        case (s_q.cpu_st)
            dbghc_pkg::DBGHC_FINISH: begin
                if (instr_done) begin
                    if (s_q.bp_after) begin
                        s_d.bp_after = 1'b0;
                    end else begin
                        s_d.cpu_st = dbghc_pkg::DBGHC_HALTED;
                    end
                end
            end
            dbghc_pkg::DBGHC_STEPPING: begin
                if (instr_done) begin
                    s_d.cpu_st = dbghc_pkg::DBGHC_HALTED;
                end
            end
            default: begin
            end
        endcase
        // Stall already while finishing, so no further instruction starts, unless a breakpoint halts after the next one
        s_d.cpu_halt = (s_d.cpu_st == dbghc_pkg::DBGHC_HALTED) ||
                       (s_d.cpu_st == dbghc_pkg::DBGHC_FINISH &&
                        !s_d.bp_after);
        s_d.cpu_regs_lock = (s_d.cpu_st == dbghc_pkg::DBGHC_HALTED);

        // Sticky flags: a new event wins over a clear in the same cycle,
        // even when the flag was already up from an older command
        if (flag_clr_illegal && !ill_set) begin
            s_d.illegal_flag = 1'b0;
        end
        if (flag_clr_no_response_flag && !nr_set) begin
            s_d.no_resp_flag = 1'b0;
        end
        s_d.rsp.illegal = s_d.illegal_flag;
        s_d.rsp.no_resp = s_d.no_resp_flag;
    end

    // State register; special single chip mode sampled at the reset edge
    // Enable comes up set too, or non-intrusive commands and halt requests would be refused
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.ack_en <= 1'b0;
            if (ssc_mode) begin
                s_q.cpu_st <= dbghc_pkg::DBGHC_HALTED;
                s_q.cpu_halt <= 1'b1;
                s_q.cpu_regs_lock <= 1'b1;
                s_q.enable <= 1'b1;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops
    assign cmd_ready            = s_q.ready;
    assign cmd_rsp              = s_q.rsp;
    assign cpu_halt             = s_q.cpu_halt;
    assign cpu_regs_lock        = s_q.cpu_regs_lock;
    assign bus_req              = s_q.bus_req;
    // Only the busy code has its upper bit set, so one flop tells stealing
    assign bus_cycle_take_bit            = s_q.bus_st[1];
    assign debug_enable_bit     = s_q.enable;
    assign clock_select_bit     = s_q.clk_sel;
    assign halted_debug_mode    = s_q.cpu_regs_lock;
    assign illegal_command_flag = s_q.illegal_flag;
    assign no_response_flag     = s_q.no_resp_flag;

endmodule

`default_nettype wire

// >>> design/dbghc_pkg.sv
// Package: constants, command classes and carrier structs for debug halt/gate
package dbghc_pkg;

    // Clock and reset timing
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned READY_CYCLES     = 10;
    localparam logic [3:0]  READY_CNT        = 4'(READY_CYCLES);
    localparam int unsigned CYCLE_TAKE_BIT_WAIT_CYC   = 512;
    localparam logic [9:0]  CYCLE_TAKE_BIT_WAIT_CNT   = 10'(CYCLE_TAKE_BIT_WAIT_CYC);
    localparam logic [7:0]  ERR_DATA_BYTE    = 8'hEE;
    localparam logic [3:0]  CNT4_ONE         = 4'h1;
    localparam logic [9:0]  CNT10_ONE        = 10'h001;

    // Command classes as decoded by the serial front end
    typedef enum logic [2:0] {
        DBGHC_CMD_NONE     = 3'h0,
        DBGHC_CMD_ALWAYS   = 3'h1,
        DBGHC_CMD_NONINTR  = 3'h2,
        DBGHC_CMD_HALT_REQ = 3'h3,
        DBGHC_CMD_ACTIVE   = 3'h4,
        DBGHC_CMD_RESUME   = 3'h5,
        DBGHC_CMD_STEP     = 3'h6,
        DBGHC_CMD_CSR_WR   = 3'h7
    } dbghc_cmd_t;

    // Execution state of the CPU as seen by the debug controller
    typedef enum logic [1:0] {
        DBGHC_RUN     = 2'b00,
        DBGHC_FINISH  = 2'b01,
        DBGHC_HALTED  = 2'b11,
        DBGHC_STEPPING = 2'b10
    } dbghc_cpu_st_t;

    // Bus access engine state
    typedef enum logic [1:0] {
        DBGHC_BUS_IDLE = 2'b00,
        DBGHC_BUS_WAIT = 2'b01,
        DBGHC_BUS_BUSY = 2'b11
    } dbghc_bus_st_t;

    // Decoded command from the serial side
    typedef struct packed {
        logic       valid;
        dbghc_cmd_t cls;
        logic       is_read;
        logic       csr_enable;
        logic       csr_clk_sel;
    } dbghc_cmd_req_t;

    // Answer to the serial side
    typedef struct packed {
        logic       done;
        logic       illegal;
        logic       no_resp;
        logic       long_ack;
        logic [7:0] rd_byte;
    } dbghc_cmd_rsp_t;

    // Whole block state
    typedef struct packed {
        logic [3:0]     rdy_cnt;
        logic           ready;
        logic           enable;
        logic           clk_sel;
        logic           ack_en;
        logic           cycle_take;
        dbghc_cpu_st_t  cpu_st;
        logic           bp_after;
        dbghc_bus_st_t  bus_st;
        logic [9:0]     wait_cnt;
        dbghc_cmd_req_t held;
        logic           held_pend;
        logic           s1_req;
        logic           s2_req;
        logic           s2_req_d;
        logic           cpu_halt;
        logic           cpu_regs_lock;
        logic           bus_req;
        logic           illegal_flag;
        logic           no_resp_flag;
        dbghc_cmd_rsp_t rsp;
    } dbghc_state_t;

endpackage

// >>> tb/dbghc_sva.sv
// Checker for halt entry, readiness and command gating of the debug block
`timescale 1ns/100ps
`default_nettype none
module dbghc_sva (
    // Core clock, reset and watched ports
    input wire logic                      ref_clk,
    input wire logic                      srst,
    input wire logic                      nvm_init_busy,
    input wire dbghc_pkg::dbghc_cmd_rsp_t cmd_rsp,
    input wire logic                      cmd_ready,
    input wire logic                      cpu_halt,
    input wire logic                      cpu_regs_lock,
    input wire logic                      bus_req,
    input wire logic                      bus_ack,
    input wire logic                      bus_cycle_take_bit,
    input wire logic                      debug_enable_bit,
    input wire logic                      halted_debug_mode,
    input wire logic                      illegal_command_flag
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_ready_on_time: assert property (
        $fell(srst) |-> !cmd_ready [*8] ##[1:3] cmd_ready)
        else $error("command ready not on time");
    a_halt_needs_enable: assert property (
        $rose(halted_debug_mode) |-> debug_enable_bit)
        else $error("halted without debug enabled");
    a_disabled_no_stall: assert property (
        !debug_enable_bit && !cpu_halt |=> !cpu_halt)
        else $error("cpu stalled while debug disabled");
    a_halted_regs_lock: assert property (
        halted_debug_mode |-> cpu_regs_lock && cpu_halt)
        else $error("registers open while halted");
    a_illegal_err_byte: assert property (
        cmd_rsp.done && $rose(illegal_command_flag) |->
        cmd_rsp.illegal && cmd_rsp.rd_byte == 8'hEE)
        else $error("illegal answer without error byte or flag");
    a_access_steals: assert property (
        $rose(bus_req) |-> bus_cycle_take_bit)
        else $error("bus access without stealing");
    a_ack_gives_done: assert property (
        bus_req && bus_ack |=> cmd_rsp.done && !bus_req)
        else $error("bus grant not answered next cycle");
    a_init_holds_bus: assert property (
        nvm_init_busy && !bus_req |=> !bus_req)
        else $error("bus access started during init");

    // Main scenarios reached
    c_halted: cover property ($rose(halted_debug_mode));
    c_illegal: cover property (cmd_rsp.done && cmd_rsp.illegal);
    c_bus_done: cover property (bus_req && bus_ack);
endmodule
bind dbghc_top dbghc_sva dbghc_sva_inst (
    .ref_clk, .srst, .nvm_init_busy, .cmd_rsp, .cmd_ready, .cpu_halt,
    .cpu_regs_lock, .bus_req, .bus_ack, .bus_cycle_take_bit, .debug_enable_bit,
    .halted_debug_mode, .illegal_command_flag
);
`default_nettype wire

// >>> tb/dbghc_host.sv
// Debug host model: sends decoded commands and keeps the host gaps
`timescale 1ns/100ps
`default_nettype none
module dbghc_host (
    // Clock and answer from the block
    input  wire logic                      ref_clk,
    input  wire logic                      cmd_ready,
    input  wire dbghc_pkg::dbghc_cmd_rsp_t cmd_rsp,
    // Command toward the block
    output var dbghc_pkg::dbghc_cmd_req_t  cmd_req,
    output var logic                       cmd_tgl
);
    // Idle lines at time zero
    initial begin
        cmd_req = '0;
        cmd_tgl = 1'b0;
    end

    // One command; held until answered, since the block syncs the toggle
    task automatic send(input dbghc_pkg::dbghc_cmd_t cls,
                        input logic [2:0] fl,
                        output dbghc_pkg::dbghc_cmd_rsp_t rsp,
                        output logic got);
        int n;
        got = 1'b0;
        for (n = 0; n < 40 && !cmd_ready; n++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        cmd_req = {1'b1, cls, fl};
        cmd_tgl = ~cmd_tgl;
        for (n = 0; n < 600 && !got; n++) begin
            @(posedge ref_clk);
            #1;
            got = cmd_rsp.done;
        end
        rsp = cmd_rsp;
        // Released lines show the inverse, never the stale command
        cmd_req = dbghc_pkg::dbghc_cmd_req_t'(~cmd_req);
        repeat (16) @(posedge ref_clk);
        if (cls == dbghc_pkg::DBGHC_CMD_CSR_WR)
            repeat (150) @(posedge ref_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> tb/dbghc_top_test.sv
// Self-checking bench for debug halt entry and command gating
`timescale 1ns/100ps
`default_nettype none
module dbghc_top_test;
    // Stimulus, observed ports and bookkeeping
    logic                      ref_clk, srst, ssc_mode, secure, nvm_init_busy;
    logic                      flag_clr_illegal, cpu_halt_instruction, bp_hit;
    logic                      bp_after_next, instr_done, bus_free, bus_ack;
    logic                      cmd_tgl, cmd_ready, cpu_halt, cpu_regs_lock;
    logic                      bus_req, bus_cycle_take_bit, debug_enable_bit, got, fin;
    logic                      clock_select_bit, halted_debug_mode;
    logic                      illegal_command_flag, no_response_flag;
    logic [7:0]                bus_rdata, seen_rd;
    dbghc_pkg::dbghc_cmd_req_t cmd_req;
    dbghc_pkg::dbghc_cmd_rsp_t cmd_rsp, rsp;
    int                        mismatches, n_compared, cyc, t_bef, t_aft;

    dbghc_top dbghc_top_inst (
        .ref_clk, .srst, .ssc_mode, .secure, .nvm_init_busy, .cmd_req,
        .cmd_tgl, .flag_clr_illegal, .flag_clr_no_response_flag(1'b0), .cmd_ready,
        .cmd_rsp, .cpu_halt_instruction, .bp_hit, .bp_after_next,
        .instr_done, .cpu_halt, .cpu_regs_lock, .bus_free, .bus_ack,
        .bus_rdata, .bus_req, .bus_cycle_take_bit, .debug_enable_bit,
        .clock_select_bit, .halted_debug_mode, .illegal_command_flag,
        .no_response_flag
    );
    dbghc_host dbghc_host_inst (
        .ref_clk, .cmd_ready, .cmd_rsp, .cmd_req, .cmd_tgl
    );

    // Clock of 100 ns
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // CPU retires every fourth cycle; the bus stalls on even cycles
    always @(posedge ref_clk) begin
        #1;
        cyc++;
        instr_done = (cyc % 4 == 0);
        bus_free = cyc[0];
        bus_rdata = 8'(cyc) ^ 8'hA5;
        bus_ack = bus_req && !bus_ack && cyc[0];
        if (bus_ack)
            seen_rd = bus_rdata;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_halt(output int n);
        for (n = 0; n < 60 && !halted_debug_mode; n++)
            tick(1);
    endtask

    // Reset for five cycles, then time the ready flag
    task automatic do_reset(input logic special_single_chip_mode);
        int n;
        srst = 1'b1;
        ssc_mode = special_single_chip_mode;
        tick(5);
        srst = 1'b0;
        for (n = 0; n < 20 && !cmd_ready; n++)
            tick(1);
        check(n >= 10 && n <= 11, 1'b1);
        check(halted_debug_mode, special_single_chip_mode);
        check(debug_enable_bit, special_single_chip_mode);
    endtask

    // Send one command and judge its answer
    task automatic exec(input dbghc_pkg::dbghc_cmd_t c, input logic [2:0] f,
                        input logic ill);
        // The flag is sticky; clear a leftover so this answer stands alone
        if (illegal_command_flag) begin
            flag_clr_illegal = 1'b1;
            tick(1);
            flag_clr_illegal = 1'b0;
        end
        dbghc_host_inst.send(c, f, rsp, got);
        check(got, 1'b1);
        check(rsp.illegal, ill);
        if (ill)
            check(rsp.rd_byte, 8'hEE);
    endtask

    task automatic pulse_bp(input logic aft);
        while (!instr_done)
            tick(1);
        bp_after_next = aft;
        bp_hit = 1'b1;
        tick(1);
        bp_hit = 1'b0;
    endtask

    task automatic t_disabled;
        exec(dbghc_pkg::DBGHC_CMD_HALT_REQ, 3'b000, 1'b1);
        check(cpu_halt, 1'b0);
        check(illegal_command_flag, 1'b1);
        flag_clr_illegal = 1'b1;
        tick(1);
        flag_clr_illegal = 1'b0;
        tick(1);
        check(illegal_command_flag, 1'b0);
        cpu_halt_instruction = 1'b1;
        tick(1);
        cpu_halt_instruction = 1'b0;
        tick(12);
        check(halted_debug_mode, 1'b0);
        exec(dbghc_pkg::DBGHC_CMD_ALWAYS, 3'b000, 1'b0);
        exec(dbghc_pkg::DBGHC_CMD_ACTIVE, 3'b000, 1'b1);
        $display("disabled gating done");
    endtask

    task automatic t_enabled;
        exec(dbghc_pkg::DBGHC_CMD_CSR_WR, 3'b011, 1'b0);
        check(debug_enable_bit, 1'b1);
        check(clock_select_bit, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_ACTIVE, 3'b000, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_HALT_REQ, 3'b000, 1'b0);
        check(halted_debug_mode, 1'b1);
        check(cpu_regs_lock, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_NONINTR, 3'b100, 1'b0);
        check(rsp.rd_byte, seen_rd);
        check(no_response_flag, 1'b0);
        exec(dbghc_pkg::DBGHC_CMD_ACTIVE, 3'b000, 1'b0);
        exec(dbghc_pkg::DBGHC_CMD_STEP, 3'b000, 1'b0);
        wait_halt(t_bef);
        check(halted_debug_mode, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_RESUME, 3'b000, 1'b0);
        check(halted_debug_mode, 1'b0);
        secure = 1'b1;
        exec(dbghc_pkg::DBGHC_CMD_NONINTR, 3'b100, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_CSR_WR, 3'b010, 1'b0);
        check(clock_select_bit, 1'b0);
        secure = 1'b0;
        $display("enabled gating done");
    endtask

    task automatic t_triggers;
        cpu_halt_instruction = 1'b1;
        tick(1);
        cpu_halt_instruction = 1'b0;
        wait_halt(t_bef);
        check(halted_debug_mode, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_RESUME, 3'b000, 1'b0);
        pulse_bp(1'b0);
        wait_halt(t_bef);
        check(halted_debug_mode, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_RESUME, 3'b000, 1'b0);
        pulse_bp(1'b1);
        wait_halt(t_aft);
        check(t_aft > t_bef, 1'b1);
        exec(dbghc_pkg::DBGHC_CMD_RESUME, 3'b000, 1'b0);
        $display("halt triggers done");
    endtask

    // Init holds a memory read back; it must finish only after init ends
    task automatic t_nvm;
        nvm_init_busy = 1'b1;
        fin = 1'b0;
        exec(dbghc_pkg::DBGHC_CMD_ALWAYS, 3'b000, 1'b0);
        fork
            begin
                exec(dbghc_pkg::DBGHC_CMD_NONINTR, 3'b100, 1'b0);
                fin = 1'b1;
            end
            begin
                tick(30);
                check(fin, 1'b0);
                nvm_init_busy = 1'b0;
            end
        join
        check(rsp.rd_byte, seen_rd);
        $display("init hold done");
    endtask

    // Special single chip start: load the start address, then resume
    task automatic t_ssc;
        do_reset(1'b1);
        exec(dbghc_pkg::DBGHC_CMD_ACTIVE, 3'b000, 1'b0);
        exec(dbghc_pkg::DBGHC_CMD_RESUME, 3'b000, 1'b0);
        check(halted_debug_mode, 1'b0);
        $display("special reset done");
    endtask

    // Main sequence
    initial begin
        {ssc_mode, secure, nvm_init_busy, flag_clr_illegal} = 4'h0;
        {cpu_halt_instruction, bp_hit, bp_after_next} = 3'h0;
        {instr_done, bus_free, bus_ack, bus_rdata, seen_rd} = 19'h0;
        {mismatches, n_compared, cyc} = 96'h0;
        srst = 1'b1;
        do_reset(1'b0);
        t_disabled;
        t_enabled;
        t_triggers;
        t_nvm;
        t_ssc;
        end_of_test;
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_of_test;
    end
endmodule
`default_nettype wire
